// *** dfd_pkg.sv ***
// Package: register map, function codes and carrier types of the input function decoder
package dfd_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NUM_TERM = 9;
    localparam int CODE_W = 7;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W = 16;
    localparam int NUM_FN = 64;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_TERM_CODE0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STAGE_CFG = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_SWING_CFG = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_COMP_CFG = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CFG = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_PERM_CFG = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_SEL_STAT = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_STAT = 8'h84;
    localparam logic [ADDR_W-1:0] OFS_TERM_STAT = 8'h88;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [CODE_W-1:0] RST_TERM_CODE = 7'h00;
    localparam logic [CFG_W-1:0] RST_CFG = 16'h0000;

    // ---------------------------------------------------------------
    // Configuration digit positions and values
    // ---------------------------------------------------------------
    localparam int DIG_ONES = 0;
    localparam int DIG_TENS = 1;
    localparam int DIG_HUND = 2;
    localparam logic [3:0] DV_ZERO = 4'h0;
    localparam logic [3:0] DV_ONE = 4'h1;
    localparam logic [3:0] DV_TWO = 4'h2;

    // ---------------------------------------------------------------
    // Function codes
    // ---------------------------------------------------------------
    localparam int FN_LO = 23;
    localparam int FN_HI = 60;
    localparam int FN_PLC_RUN = 23;
    localparam int FN_SWING_RUN = 24;
    localparam int FN_COMP_PID = 25;
    localparam int FN_PLC_CLR = 26;
    localparam int FN_SWING_CLR = 27;
    localparam int FN_PID_STG1 = 28;
    localparam int FN_PID_STG2 = 29;
    localparam int FN_PID_STG3 = 30;
    localparam int FN_PID_SP = 31;
    localparam int FN_PID_FB = 32;
    localparam int FN_PID_SLEEP = 33;
    localparam int FN_TORQUE = 34;
    localparam int FN_TLIM_MIN = 35;
    localparam int FN_TLIM_MAX = 36;
    localparam int FN_RSV_A_LO = 37;
    localparam int FN_RSV_A_HI = 39;
    localparam int FN_PANEL = 40;
    localparam int FN_RSV_B = 41;
    localparam int FN_START_PERM = 42;
    localparam int FN_RUN_PERM = 43;
    localparam int FN_CNT_CLK = 44;
    localparam int FN_CNT_TRIG = 46;
    localparam int FN_CNT_RST = 48;
    localparam int FN_CNT_GATE = 50;
    localparam int FN_TMR_TRIG = 52;
    localparam int FN_TMR_RST = 55;
    localparam int FN_TMR_GATE = 58;
    localparam int NUM_CNT = 2;
    localparam int NUM_TMR = 3;

    // ---------------------------------------------------------------
    // Carrier types
    // ---------------------------------------------------------------
    typedef logic [CODE_W-1:0] dfd_code_t;

    typedef struct packed {
        logic run_perm;
        logic start_perm;
        logic remote_panel;
        logic tlim_max2;
        logic tlim_min2;
        logic torque_mode;
        logic pid_sleep;
        logic pid_fb2;
        logic pid_sp2;
        logic [2:0] pid_stage;
        logic swing_clear;
        logic plc_clear;
        logic comp_pid_en;
        logic swing_to_preset;
        logic swing_run;
        logic plc_run;
    } dfd_sel_t;

    typedef struct packed {
        logic [NUM_TMR-1:0] tmr_gate;
        logic [NUM_TMR-1:0] tmr_rst;
        logic [NUM_TMR-1:0] tmr_trig;
        logic [NUM_CNT-1:0] cnt_gate;
        logic [NUM_CNT-1:0] cnt_rst;
        logic [NUM_CNT-1:0] cnt_trig;
        logic [NUM_CNT-1:0] cnt_clk;
    } dfd_route_t;

endpackage

// *** dfd_sync.sv ***
// Two-flop synchroniser for the terminal levels
`timescale 1ns/1ps
module dfd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // dfd_sync

// *** dfd_term_decode.sv ***
// Maps terminal levels through their function codes onto a function-active vector
`timescale 1ns/1ps
module dfd_term_decode (
    input wire logic [dfd_pkg::NUM_TERM-1:0] term_level,
    input wire dfd_pkg::dfd_code_t term_code [dfd_pkg::NUM_TERM],
    output logic [dfd_pkg::NUM_FN-1:0] fn_active
);
    // ---------------------------------------------------------------
    // Codes that steer something
    // ---------------------------------------------------------------
    function automatic logic code_used(input dfd_pkg::dfd_code_t c);
        int v;
        v = int'(c);
        code_used = (v >= dfd_pkg::FN_LO) && (v <= dfd_pkg::FN_HI)
            && !((v >= dfd_pkg::FN_RSV_A_LO) && (v <= dfd_pkg::FN_RSV_A_HI))
            && (v != dfd_pkg::FN_RSV_B);
    endfunction

    // Several terminals on one code combine as a wired OR
    always_comb begin
        fn_active = '0;
        for (int t = 0; t < dfd_pkg::NUM_TERM; t++) begin
            if (term_level[t] && code_used(term_code[t])) begin
                fn_active[term_code[t][5:0]] = 1'b1;
            end
        end
    end
endmodule // dfd_term_decode

// *** dfd_core.sv ***
// Input function decoder: terminal function codes to drive control selections
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dfd_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [dfd_pkg::NUM_TERM-1:0] term_in,
    input wire logic drive_stopped,
    input wire logic [dfd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dfd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dfd_pkg::DATA_W-1:0] reg_rdata,
    output dfd_pkg::dfd_sel_t sel_q,
    output dfd_pkg::dfd_route_t route_q
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] cfg_digit(input logic [dfd_pkg::CFG_W-1:0] cfg,
                                             input int idx);
        cfg_digit = cfg[idx*4 +: 4];
    endfunction

    function automatic logic digit_one_or_two(input logic [3:0] d);
        digit_one_or_two = (d == dfd_pkg::DV_ONE) || (d == dfd_pkg::DV_TWO);
    endfunction

    // ---------------------------------------------------------------
    // Terminal synchroniser and decoder
    // ---------------------------------------------------------------
    logic [dfd_pkg::NUM_TERM-1:0] term_sync;
    logic [dfd_pkg::NUM_FN-1:0] fn;
    dfd_pkg::dfd_code_t term_code_q [dfd_pkg::NUM_TERM];

    dfd_sync #(
        .WIDTH(dfd_pkg::NUM_TERM)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(term_in),
        .sync_out(term_sync)
    );

    dfd_term_decode u_decode (
        .term_level(term_sync),
        .term_code(term_code_q),
        .fn_active(fn)
    );

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    logic [dfd_pkg::CFG_W-1:0] stage_sequencer_config_q;
    logic [dfd_pkg::CFG_W-1:0] swing_mode_config_q;
    logic [dfd_pkg::CFG_W-1:0] compensation_loop_config_q;
    logic [dfd_pkg::CFG_W-1:0] sleep_source_config_q;
    logic [dfd_pkg::CFG_W-1:0] permission_config_q;
    logic [dfd_pkg::DATA_W-1:0] reg_rdata_d;

    wire logic hit_code = (reg_addr < dfd_pkg::OFS_TERM_CODE0
        + dfd_pkg::ADDR_W'(4 * dfd_pkg::NUM_TERM)) && (reg_addr[1:0] == 2'h0);
    wire logic [3:0] code_idx = reg_addr[5:2];
    wire logic wr_stage = reg_wr && (reg_addr == dfd_pkg::OFS_STAGE_CFG);
    wire logic wr_swing = reg_wr && (reg_addr == dfd_pkg::OFS_SWING_CFG);
    wire logic wr_comp = reg_wr && (reg_addr == dfd_pkg::OFS_COMP_CFG);
    wire logic wr_sleep = reg_wr && (reg_addr == dfd_pkg::OFS_SLEEP_CFG);
    wire logic wr_perm = reg_wr && (reg_addr == dfd_pkg::OFS_PERM_CFG);

    // Read mux; unmapped addresses answer zero
    always_comb begin
        reg_rdata_d = '0;
        if (!reg_rd) begin
            reg_rdata_d = '0;
        end else if (hit_code) begin
            reg_rdata_d = dfd_pkg::DATA_W'(term_code_q[code_idx]);
        end else if (reg_addr == dfd_pkg::OFS_STAGE_CFG) begin
            reg_rdata_d = dfd_pkg::DATA_W'(stage_sequencer_config_q);
        end else if (reg_addr == dfd_pkg::OFS_SWING_CFG) begin
            reg_rdata_d = dfd_pkg::DATA_W'(swing_mode_config_q);
        end else if (reg_addr == dfd_pkg::OFS_COMP_CFG) begin
            reg_rdata_d = dfd_pkg::DATA_W'(compensation_loop_config_q);
        end else if (reg_addr == dfd_pkg::OFS_SLEEP_CFG) begin
            reg_rdata_d = dfd_pkg::DATA_W'(sleep_source_config_q);
        end else if (reg_addr == dfd_pkg::OFS_PERM_CFG) begin
            reg_rdata_d = dfd_pkg::DATA_W'(permission_config_q);
        end else if (reg_addr == dfd_pkg::OFS_SEL_STAT) begin
            reg_rdata_d = dfd_pkg::DATA_W'(sel_q);
        end else if (reg_addr == dfd_pkg::OFS_ROUTE_STAT) begin
            reg_rdata_d = dfd_pkg::DATA_W'(route_q);
        end else if (reg_addr == dfd_pkg::OFS_TERM_STAT) begin
            reg_rdata_d = dfd_pkg::DATA_W'(term_sync);
        end
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int t = 0; t < dfd_pkg::NUM_TERM; t++) begin
                term_code_q[t] <= dfd_pkg::RST_TERM_CODE;
            end
        end else if (reg_wr && hit_code) begin
            term_code_q[code_idx] <= reg_wdata[dfd_pkg::CODE_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage_sequencer_config_q <= dfd_pkg::RST_CFG;
            swing_mode_config_q <= dfd_pkg::RST_CFG;
            compensation_loop_config_q <= dfd_pkg::RST_CFG;
            sleep_source_config_q <= dfd_pkg::RST_CFG;
            permission_config_q <= dfd_pkg::RST_CFG;
        end else begin
            if (wr_stage) begin
                stage_sequencer_config_q <= reg_wdata[dfd_pkg::CFG_W-1:0];
            end
            if (wr_swing) begin
                swing_mode_config_q <= reg_wdata[dfd_pkg::CFG_W-1:0];
            end
            if (wr_comp) begin
                compensation_loop_config_q <= reg_wdata[dfd_pkg::CFG_W-1:0];
            end
            if (wr_sleep) begin
                sleep_source_config_q <= reg_wdata[dfd_pkg::CFG_W-1:0];
            end
            if (wr_perm) begin
                permission_config_q <= reg_wdata[dfd_pkg::CFG_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Configuration qualifiers
    // ---------------------------------------------------------------
    wire logic plc_by_term = cfg_digit(stage_sequencer_config_q, dfd_pkg::DIG_ONES)
        == dfd_pkg::DV_TWO;
    wire logic plc_memory = digit_one_or_two(
        cfg_digit(stage_sequencer_config_q, dfd_pkg::DIG_HUND));
    wire logic swing_by_term = cfg_digit(swing_mode_config_q, dfd_pkg::DIG_ONES)
        == dfd_pkg::DV_TWO;
    wire logic swing_memory = cfg_digit(swing_mode_config_q, dfd_pkg::DIG_TENS)
        == dfd_pkg::DV_ZERO;
    wire logic comp_by_term = cfg_digit(compensation_loop_config_q, dfd_pkg::DIG_ONES)
        == dfd_pkg::DV_TWO;
    wire logic sleep_by_term = sleep_source_config_q
        == dfd_pkg::CFG_W'(dfd_pkg::DV_TWO);
    wire logic start_perm_on = digit_one_or_two(
        cfg_digit(permission_config_q, dfd_pkg::DIG_ONES));
    wire logic run_perm_on = digit_one_or_two(
        cfg_digit(permission_config_q, dfd_pkg::DIG_HUND));

    // ---------------------------------------------------------------
    // Selection decode
    // ---------------------------------------------------------------
    dfd_pkg::dfd_sel_t sel_d;
    dfd_pkg::dfd_route_t route_d;

    assign sel_d.plc_run = plc_by_term && fn[dfd_pkg::FN_PLC_RUN];
    assign sel_d.swing_run = swing_by_term && fn[dfd_pkg::FN_SWING_RUN];
    // Ramp to preset frequency on the accel time already selected elsewhere
    assign sel_d.swing_to_preset = swing_by_term && !fn[dfd_pkg::FN_SWING_RUN];
    assign sel_d.comp_pid_en = comp_by_term && fn[dfd_pkg::FN_COMP_PID];
    // Clears are gated by the stop state so a running sequence is never disturbed
    assign sel_d.plc_clear = plc_memory && drive_stopped
        && fn[dfd_pkg::FN_PLC_CLR];
    assign sel_d.swing_clear = swing_memory && drive_stopped
        && fn[dfd_pkg::FN_SWING_CLR];
    assign sel_d.pid_stage = {fn[dfd_pkg::FN_PID_STG3], fn[dfd_pkg::FN_PID_STG2],
        fn[dfd_pkg::FN_PID_STG1]};
    assign sel_d.pid_sp2 = fn[dfd_pkg::FN_PID_SP];
    assign sel_d.pid_fb2 = fn[dfd_pkg::FN_PID_FB];
    assign sel_d.pid_sleep = sleep_by_term && fn[dfd_pkg::FN_PID_SLEEP];
    assign sel_d.torque_mode = fn[dfd_pkg::FN_TORQUE];
    assign sel_d.tlim_min2 = fn[dfd_pkg::FN_TLIM_MIN];
    assign sel_d.tlim_max2 = fn[dfd_pkg::FN_TLIM_MAX];
    assign sel_d.remote_panel = fn[dfd_pkg::FN_PANEL];
    assign sel_d.start_perm = start_perm_on && fn[dfd_pkg::FN_START_PERM];
    assign sel_d.run_perm = run_perm_on && fn[dfd_pkg::FN_RUN_PERM];

    assign route_d.cnt_clk = fn[dfd_pkg::FN_CNT_CLK +: dfd_pkg::NUM_CNT];
    assign route_d.cnt_trig = fn[dfd_pkg::FN_CNT_TRIG +: dfd_pkg::NUM_CNT];
    assign route_d.cnt_rst = fn[dfd_pkg::FN_CNT_RST +: dfd_pkg::NUM_CNT];
    assign route_d.cnt_gate = fn[dfd_pkg::FN_CNT_GATE +: dfd_pkg::NUM_CNT];
    assign route_d.tmr_trig = fn[dfd_pkg::FN_TMR_TRIG +: dfd_pkg::NUM_TMR];
    assign route_d.tmr_rst = fn[dfd_pkg::FN_TMR_RST +: dfd_pkg::NUM_TMR];
    assign route_d.tmr_gate = fn[dfd_pkg::FN_TMR_GATE +: dfd_pkg::NUM_TMR];

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_q <= '0;
            route_q <= '0;
        end else begin
            sel_q <= sel_d;
            route_q <= route_d;
        end
    end
endmodule // dfd_core

// *** dfd_term_src.sv ***
// Terminal source: external contacts feeding the decoder's terminal inputs
`timescale 1ns/1ps
module dfd_term_src (
    input wire logic core_clk,
    input wire logic [8:0] want,
    output logic [8:0] term_in
);
    // Contacts are plain levels; each change lands just after a clock edge
    initial term_in = 9'h000;
    always @(posedge core_clk) begin
        term_in <= want;
    end
endmodule // dfd_term_src

// *** dfd_core_asserts.sv ***
// Checker: port-level properties of the input function decoder
`timescale 1ns/1ps
module dfd_core_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [dfd_pkg::NUM_TERM-1:0] term_in,
    input wire logic drive_stopped,
    input wire logic [dfd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dfd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dfd_pkg::DATA_W-1:0] reg_rdata,
    input wire dfd_pkg::dfd_sel_t sel_q,
    input wire dfd_pkg::dfd_route_t route_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    reset_clear_a:
        assert property ($fell(rst) |-> sel_q == '0 && route_q == '0 && reg_rdata == '0)
        else $error("outputs not clear after reset");
    idle_rdata_a:
        assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data present without a read");
    unmapped_read_a:
        assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    sel_readback_a:
        assert property (reg_rd && reg_addr == dfd_pkg::OFS_SEL_STAT
            |=> reg_rdata == {14'h0, $past(sel_q)}) else $error("selection status mismatch");
    route_readback_a:
        assert property (reg_rd && reg_addr == dfd_pkg::OFS_ROUTE_STAT
            |=> reg_rdata == {15'h0, $past(route_q)}) else $error("route status mismatch");

    // ---------------------------------------------------------------
    // Selections
    // ---------------------------------------------------------------
    seq_clear_gate_a:
        assert property (sel_q.plc_clear |-> $past(drive_stopped))
        else $error("sequencer clear while running");
    swing_clear_gate_a:
        assert property (sel_q.swing_clear |-> $past(drive_stopped))
        else $error("swing clear while running");
    swing_excl_a:
        assert property (!(sel_q.swing_run && sel_q.swing_to_preset))
        else $error("swing run and preset together");
    quiet_hold_a:
        assert property ((!reg_wr && $stable(term_in) && $stable(drive_stopped))[*5]
            |-> $stable(sel_q) && $stable(route_q)) else $error("outputs moved without cause");
endmodule // dfd_core_chk

bind dfd_core dfd_core_chk chk_i (.core_clk(core_clk), .rst(rst), .term_in(term_in),
    .drive_stopped(drive_stopped), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_q(sel_q),
    .route_q(route_q));

// *** tb.sv ***
// Testbench: directed and random checks of the input function decoder
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic drive_stopped = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [8:0] want = 9'h000;
    logic [8:0] term_in;
    dfd_pkg::dfd_sel_t sel_q;
    dfd_pkg::dfd_route_t route_q;
    dfd_pkg::dfd_code_t code [9];
    logic [15:0] cfg [5];
    // All features under terminal control, sequencer and swing memory on
    logic [15:0] cfg_on [5] = '{16'h0102, 16'h0002, 16'h0002, 16'h0002, 16'h0101};
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] d;

    dfd_term_src src (.core_clk(core_clk), .want(want), .term_in(term_in));
    dfd_core dut (.core_clk(core_clk), .rst(rst), .term_in(term_in),
        .drive_stopped(drive_stopped), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_q(sel_q),
        .route_q(route_q));

    always #4 core_clk = ~core_clk;

    // ---------------------------------------------------------------
    // Expectations
    // ---------------------------------------------------------------
    function automatic logic [63:0] active();
        logic [63:0] a;
        a = '0;
        for (int k = 0; k < 9; k++) begin
            if (want[k] && code[k] < 7'h40) a[code[k][5:0]] = 1'b1;
        end
        return a;
    endfunction
    function automatic logic one_two(input logic [3:0] n);
        return n == 4'h1 || n == 4'h2;
    endfunction
    function automatic logic [31:0] exp_sel();
        logic [63:0] a;
        dfd_pkg::dfd_sel_t s;
        a = active();
        s = '0;
        s.plc_run = a[23] && cfg[0][3:0] == 4'h2;
        s.swing_run = a[24] && cfg[1][3:0] == 4'h2;
        s.swing_to_preset = !a[24] && cfg[1][3:0] == 4'h2;
        s.comp_pid_en = a[25] && cfg[2][3:0] == 4'h2;
        s.plc_clear = a[26] && drive_stopped && one_two(cfg[0][11:8]);
        s.swing_clear = a[27] && drive_stopped && cfg[1][7:4] == 4'h0;
        s.pid_stage = {a[30], a[29], a[28]};
        s.pid_sp2 = a[31];
        s.pid_fb2 = a[32];
        s.pid_sleep = a[33] && cfg[3] == 16'h0002;
        s.torque_mode = a[34];
        s.tlim_min2 = a[35];
        s.tlim_max2 = a[36];
        s.remote_panel = a[40];
        s.start_perm = a[42] && one_two(cfg[4][3:0]);
        s.run_perm = a[43] && one_two(cfg[4][11:8]);
        return {14'h0, s};
    endfunction
    function automatic logic [31:0] exp_route();
        logic [63:0] a;
        a = active();
        return {15'h0, a[60:44]};
    endfunction
    function automatic logic [15:0] rcfg();
        return {4'h0, 4'($urandom_range(3)), 4'($urandom_range(3)), 4'($urandom_range(3))};
    endfunction

    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task automatic check32(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Idle edge so a following call never re-drives the strobe in this step
        @(posedge core_clk);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Read data stand for this one cycle; take them mid-cycle, settled
        @(negedge core_clk);
        v = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic set_code(input int k, input logic [6:0] c);
        code[k] = c;
        reg_write(8'(4 * k), {25'h0, c});
    endtask
    task automatic set_cfg(input int i, input logic [15:0] v);
        cfg[i] = v;
        reg_write(8'h40 + 8'(4 * i), {16'h0, v});
    endtask
    task automatic check_out();
        repeat (5) @(posedge core_clk);
        check32({14'h0, sel_q}, exp_sel());
        check32({15'h0, route_q}, exp_route());
    endtask
    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(91));
        for (int k = 0; k < 9; k++) code[k] = '0;
        for (int i = 0; i < 5; i++) cfg[i] = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Reset values, unmapped space, read-only status and field widths
        for (int i = 0; i < 64; i++) begin
            reg_read(8'(4 * i), d);
            check32(d, 32'h0);
        end
        reg_write(dfd_pkg::OFS_SEL_STAT, 32'hFFFFFFFF);
        reg_read(dfd_pkg::OFS_SEL_STAT, d);
        check32(d, 32'h0);
        reg_write(dfd_pkg::OFS_TERM_CODE0, 32'hFFFFFFFF);
        reg_read(dfd_pkg::OFS_TERM_CODE0, d);
        check32(d, 32'h0000007F);
        reg_write(dfd_pkg::OFS_PERM_CFG, 32'hFFFFFFFF);
        reg_read(dfd_pkg::OFS_PERM_CFG, d);
        check32(d, 32'h0000FFFF);
        // Codes 20 to 63 on one terminal, active then inactive
        for (int i = 0; i < 5; i++) set_cfg(i, cfg_on[i]);
        drive_stopped <= 1'b1;
        for (int c = 20; c < 64; c++) begin
            set_code(0, 7'(c));
            want <= 9'h001;
            check_out();
            want <= 9'h000;
            check_out();
        end
        // Mid-run reset while selections are non-zero
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 9; k++) code[k] = '0;
        for (int i = 0; i < 5; i++) cfg[i] = '0;
        @(posedge core_clk);
        check32({14'h0, sel_q}, 32'h0);
        reg_read(dfd_pkg::OFS_STAGE_CFG, d);
        check32(d, 32'h0);
        reg_read(dfd_pkg::OFS_TERM_CODE0, d);
        check32(d, 32'h0);
        // Full stage index walk
        for (int k = 0; k < 3; k++) set_code(k, 7'(28 + k));
        for (int i = 0; i < 8; i++) begin
            want <= 9'(i);
            check_out();
        end
        // Random codes, configs, levels and stop state
        for (int n = 0; n < 60; n++) begin
            for (int k = 0; k < 9; k++) set_code(k, 7'($urandom_range(70, 20)));
            for (int i = 0; i < 5; i++) set_cfg(i, rcfg());
            want <= 9'($urandom);
            drive_stopped <= 1'($urandom);
            check_out();
            reg_read(dfd_pkg::OFS_SEL_STAT, d);
            check32(d, exp_sel());
            reg_read(dfd_pkg::OFS_ROUTE_STAT, d);
            check32(d, exp_route());
        end
        report_and_stop();
    end
endmodule // tb
